// ---- common/cmt_defines.vh ----
`ifndef CMT_DEFINES_VH
`define CMT_DEFINES_VH
`define CMT_I2C_ADDR        7'h45
`define CMT_REG_SETUP       8'h00
`define CMT_REG_STATUS      8'h01
`define CMT_SETUP_MASK      8'h3F
`define CMT_STATUS_WR_MASK  8'h03
`define CMT_SETUP_RESET     8'h00
`define CMT_STATUS_RESET    8'h01
`define CMT_BIT_CHEM        5
`define CMT_BIT_VSEL        4
`define CMT_BIT_GREEN       3
`define CMT_BIT_RED         2
`define CMT_TIMER_HOURS_X10 56
`define CMT_CLK_HZ          40000000
`define CMT_TIMER_CYCLES    (`CMT_TIMER_HOURS_X10 * 40'd360 * `CMT_CLK_HZ)
`endif

// ---- core/cmt_safety_timer.v ----
`timescale 1ns/1ps
`default_nettype none
module cmt_safety_timer #(
	parameter [39:0] CYCLES = 40'd806400000000
) (
	input  wire clock,
	input  wire rst,
	input  wire run,
	input  wire clear,
	output reg  expired_ff
);
	reg [39:0] count_ff;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			count_ff   <= 40'h0000000000;
			expired_ff <= 1'b0;
		end else if (clear) begin
			count_ff   <= 40'h0000000000;
			expired_ff <= 1'b0;
		end else if (run && !expired_ff) begin
			count_ff <= count_ff + 40'h0000000001;
			if (count_ff == CYCLES - 40'h0000000001)
				expired_ff <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- core/cmt_i2c_slave.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cmt_defines.vh"
// Byte-level I2C slave; scl/sda sampled on the system clock.
module cmt_i2c_slave (
	input  wire       clock,
	input  wire       rst,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_oe_ff,
	output reg        wr_stb_ff,
	output reg  [7:0] wr_addr_ff,
	output reg  [7:0] wr_data_ff,
	output wire [7:0] rd_addr,
	input  wire [7:0] rd_data
);
	localparam [2:0] S_IDLE = 3'd0, S_DEV = 3'd1, S_ACK = 3'd2, S_REG = 3'd3,
		S_DATA = 3'd4, S_TX = 3'd5, S_MACK = 3'd6;
	reg [2:0] st_ff;
	reg       scl_d_ff, sda_d_ff;
	reg [7:0] sh_ff;
	reg [3:0] cnt_ff;
	reg [7:0] ptr_ff;
	reg [2:0] after_ff;
	wire scl_rise = scl_in && !scl_d_ff;
	wire scl_fall = !scl_in && scl_d_ff;
	wire start    = scl_in && scl_d_ff && sda_d_ff && !sda_in;
	wire stop     = scl_in && scl_d_ff && !sda_d_ff && sda_in;
	assign rd_addr = ptr_ff;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff <= S_IDLE; scl_d_ff <= 1'b1; sda_d_ff <= 1'b1;
			sh_ff <= 8'h00; cnt_ff <= 4'h0; ptr_ff <= 8'h00;
			after_ff <= S_IDLE; sda_oe_ff <= 1'b0; wr_stb_ff <= 1'b0;
			wr_addr_ff <= 8'h00; wr_data_ff <= 8'h00;
		end else begin
			scl_d_ff  <= scl_in;
			sda_d_ff  <= sda_in;
			wr_stb_ff <= 1'b0;
			if (start) begin // Repeated start allowed
				st_ff <= S_DEV; cnt_ff <= 4'h0; sda_oe_ff <= 1'b0;
			end else if (stop) begin
				st_ff <= S_IDLE; sda_oe_ff <= 1'b0;
			end else begin
				case (st_ff)
				S_DEV, S_REG, S_DATA: begin
					if (scl_rise) begin
						sh_ff  <= {sh_ff[6:0], sda_in};
						cnt_ff <= cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == 4'h8) begin
						cnt_ff <= 4'h0;
						if (st_ff == S_DEV) begin
							if (sh_ff[7:1] == `CMT_I2C_ADDR) begin
								sda_oe_ff <= 1'b1;
								after_ff  <= sh_ff[0] ? S_TX : S_REG;
								st_ff     <= S_ACK;
							end else
								st_ff <= S_IDLE;
						end else if (st_ff == S_REG) begin
							ptr_ff <= sh_ff; sda_oe_ff <= 1'b1;
							after_ff <= S_DATA; st_ff <= S_ACK;
						end else begin
							wr_stb_ff <= 1'b1; wr_addr_ff <= ptr_ff;
							wr_data_ff <= sh_ff; ptr_ff <= ptr_ff + 8'h01;
							sda_oe_ff <= 1'b1; after_ff <= S_DATA; st_ff <= S_ACK;
						end
					end
				end
				S_ACK: if (scl_fall) begin
					st_ff <= after_ff;
					if (after_ff == S_TX) begin
						sh_ff <= rd_data; cnt_ff <= 4'h0;
						sda_oe_ff <= !rd_data[7];
					end else
						sda_oe_ff <= 1'b0;
				end
				S_TX: if (scl_fall) begin
					if (cnt_ff == 4'h7) begin
						sda_oe_ff <= 1'b0; st_ff <= S_MACK;
						ptr_ff <= ptr_ff + 8'h01;
					end else begin
						sh_ff <= {sh_ff[6:0], 1'b0};
						sda_oe_ff <= !sh_ff[6];
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
				S_MACK: if (scl_rise) begin
					st_ff <= sda_in ? S_IDLE : S_ACK;
					after_ff <= S_TX;
				end
				default: st_ff <= S_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- core/cmt_charger_ctrl.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cmt_defines.vh"
module cmt_charger_ctrl #(
	parameter [39:0] TIMER_CYCLES = `CMT_TIMER_CYCLES
) (
	input  wire       clock,
	input  wire       rst,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	input  wire       battery_present_n,
	input  wire       charger_enable,
	input  wire       timer_bypass_n,
	input  wire       adapter_ok,
	input  wire       precharge_done,
	input  wire       voltage_reached,
	input  wire       eoc_current_reached,
	input  wire       recharge_needed,
	input  wire       battery_above_retention,
	output reg        fixed_regulator_mode,
	output reg        charger_on,
	output reg        cc_phase,
	output reg        cv_only,
	output reg  [9:0] charge_current_ma,
	output reg        vreg_high,
	output reg  [1:0] eoc_select,
	output reg        red_led_n_oe,
	output reg        green_led_n_oe
);
	localparam [2:0] C_OFF = 3'd0, C_PRE = 3'd1, C_CC = 3'd2, C_CV = 3'd3,
		C_MAINT = 3'd4, C_FAULT = 3'd5, C_NIMH = 3'd6;
	reg [2:0] st_ff, nxt_st;
	reg [5:0] setup_ff;
	reg [1:0] eoc_sel_ff;
	reg       maint_seen_ff;
	wire      timer_expired;
	wire      wr_stb;
	wire [7:0] wr_addr, wr_data, rd_addr;
	reg  [7:0] rd_data;
	wire       chem_nimh = setup_ff[`CMT_BIT_CHEM];
	wire       active = !battery_present_n && charger_enable && adapter_ok;
	// Nickel charging counts as charging, so status bit and LED agree
	wire       red_st = ((st_ff == C_PRE || st_ff == C_CC || st_ff == C_CV) && !maint_seen_ff) ||
		(st_ff == C_NIMH);
	wire       grn_st = (st_ff == C_MAINT) ||
		((st_ff == C_CC || st_ff == C_CV || st_ff == C_PRE) && maint_seen_ff);

	function [9:0] code_to_ma;
		input [3:0] code;
		begin
			if (code > 4'h9)
				code_to_ma = 10'd950;
			else
				code_to_ma = 10'd500 + {6'd0, code} * 10'd50;
		end
	endfunction

	cmt_i2c_slave u_i2c (
		.clock      (clock),
		.rst        (rst),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.sda_oe_ff  (sda_oe),
		.wr_stb_ff  (wr_stb),
		.wr_addr_ff (wr_addr),
		.wr_data_ff (wr_data),
		.rd_addr    (rd_addr),
		.rd_data    (rd_data)
	);
	assign sda_out = 1'b0;

	// Timer runs only in lithium constant current; cleared on leaving it
	cmt_safety_timer #(.CYCLES(TIMER_CYCLES)) u_timer (
		.clock      (clock),
		.rst        (rst),
		.run        (st_ff == C_CC && !chem_nimh),
		.clear      (st_ff != C_CC),
		.expired_ff (timer_expired)
	);

	always @* begin
		case (rd_addr)
		`CMT_REG_SETUP:  rd_data = {2'b00, setup_ff};
		`CMT_REG_STATUS: rd_data = {4'h0, grn_st, red_st, eoc_sel_ff};
		default:         rd_data = 8'h00;
		endcase
	end

	// Registers lost on reset or when battery drops below retention level
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			setup_ff   <= 6'h00;
			eoc_sel_ff <= 2'b01;
		end else if (!battery_above_retention) begin
			setup_ff   <= 6'h00;
			eoc_sel_ff <= 2'b01;
		end else if (wr_stb) begin
			if (wr_addr == `CMT_REG_SETUP)
				setup_ff <= wr_data[5:0];
			else if (wr_addr == `CMT_REG_STATUS)
				eoc_sel_ff <= wr_data[1:0];
		end
	end

	always @* begin
		nxt_st = st_ff;
		if (!active)
			nxt_st = C_OFF;
		else begin
			case (st_ff)
			C_OFF:   nxt_st = chem_nimh ? C_NIMH : C_PRE;
			C_PRE:   if (precharge_done) nxt_st = C_CC;
			C_CC: begin
				if (timer_expired)
					nxt_st = timer_bypass_n ? C_FAULT : C_MAINT;
				else if (voltage_reached)
					nxt_st = C_CV;
			end
			C_CV:    if (eoc_current_reached) nxt_st = C_MAINT;
			C_MAINT: if (recharge_needed) nxt_st = C_PRE;
			C_FAULT: nxt_st = C_FAULT;
			C_NIMH:  nxt_st = C_NIMH;
			default: nxt_st = C_OFF;
			endcase
			if (st_ff != C_FAULT && st_ff != C_OFF && (chem_nimh != (st_ff == C_NIMH)))
				nxt_st = C_OFF;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff         <= C_OFF;
			maint_seen_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (!active)
				maint_seen_ff <= 1'b0;
			else if (st_ff == C_MAINT)
				maint_seen_ff <= 1'b1;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			fixed_regulator_mode <= 1'b1;
			charger_on           <= 1'b0;
			cc_phase             <= 1'b0;
			cv_only              <= 1'b0;
			charge_current_ma    <= 10'd500;
			vreg_high            <= 1'b0;
			eoc_select           <= 2'b01;
			red_led_n_oe         <= 1'b0;
			green_led_n_oe       <= 1'b0;
		end else begin
			fixed_regulator_mode <= battery_present_n && charger_enable;
			charger_on <= active && st_ff != C_OFF && st_ff != C_FAULT;
			// Same gating as charger_on, so a dropped enable never shows CC
			cc_phase   <= active && st_ff == C_CC && !chem_nimh;
			cv_only    <= chem_nimh;
			charge_current_ma <= code_to_ma(setup_ff[3:0]);
			vreg_high  <= setup_ff[`CMT_BIT_VSEL];
			eoc_select <= eoc_sel_ff;
			if (battery_present_n) begin
				red_led_n_oe   <= 1'b0;
				green_led_n_oe <= 1'b0;
			end else if (!charger_enable) begin
				red_led_n_oe   <= 1'b0;
				green_led_n_oe <= 1'b1;
			end else if (st_ff == C_FAULT) begin
				red_led_n_oe   <= 1'b1;
				green_led_n_oe <= 1'b1;
			end else begin
				red_led_n_oe   <= red_st;
				green_led_n_oe <= grn_st;
			end
		end
	end
endmodule
`default_nettype wire

// ---- bench/cmt_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module cmt_props #(
	parameter [39:0] TIMER_CYCLES = 40'd100
) (
	input wire       clock,
	input wire       rst,
	input wire       scl_in,
	input wire       sda_oe,
	input wire       battery_present_n,
	input wire       charger_enable,
	input wire       fixed_regulator_mode,
	input wire       charger_on,
	input wire       cc_phase,
	input wire       cv_only,
	input wire [9:0] charge_current_ma,
	input wire       red_led_n_oe,
	input wire       green_led_n_oe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	reg [39:0] cc_cnt_ff;
	// Length of the current constant-current stretch
	always @(posedge clock or posedge rst) begin
		if (rst)
			cc_cnt_ff <= 40'h0;
		else
			cc_cnt_ff <= cc_phase ? cc_cnt_ff + 40'h1 : 40'h0;
	end
	sequence s_leds_both;
		red_led_n_oe && green_led_n_oe;
	endsequence
	sequence s_regulator_held;
		fixed_regulator_mode [*3];
	endsequence
	property p_mode;
		($stable(battery_present_n) && $stable(charger_enable)) [*4]
			|-> fixed_regulator_mode == (battery_present_n && charger_enable);
	endproperty
	property p_enable;
		!charger_enable [*3] |-> !charger_on && !cc_phase;
	endproperty
	property p_regulator_dark;
		s_regulator_held |-> !red_led_n_oe && !green_led_n_oe;
	endproperty
	property p_fault;
		s_leds_both |-> !charger_on && !cc_phase;
	endproperty
	property p_cc;
		cc_phase |-> charger_on && !cv_only && !fixed_regulator_mode;
	endproperty
	property p_timer;
		cc_cnt_ff <= TIMER_CYCLES + 40'd4;
	endproperty
	property p_sda;
		!$stable(sda_oe) |-> !scl_in;
	endproperty
	property p_current;
		charge_current_ma >= 10'd500 && charge_current_ma <= 10'd950
			&& charge_current_ma % 10'd50 == 10'd0;
	endproperty
	a_mode: assert property (p_mode) else $error("mode wrong");
	a_enable: assert property (p_enable) else $error("enable ignored");
	a_regulator_dark: assert property (p_regulator_dark) else $error("led lit");
	a_fault: assert property (p_fault) else $error("fault charging");
	a_cc: assert property (p_cc) else $error("cc state wrong");
	a_timer: assert property (p_timer) else $error("timer overrun");
	a_sda: assert property (p_sda) else $error("sda moved, scl high");
	a_current: assert property (p_current) else $error("current off grid");
endmodule
bind cmt_charger_ctrl cmt_props #(.TIMER_CYCLES(TIMER_CYCLES)) u_props (
	.clock(clock), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe),
	.battery_present_n(battery_present_n), .charger_enable(charger_enable),
	.fixed_regulator_mode(fixed_regulator_mode), .charger_on(charger_on),
	.cc_phase(cc_phase), .cv_only(cv_only), .charge_current_ma(charge_current_ma),
	.red_led_n_oe(red_led_n_oe), .green_led_n_oe(green_led_n_oe));
`default_nettype wire

// ---- bench/cmt_i2c_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module cmt_i2c_master (
	input  wire logic clock,
	input  wire logic sda,
	output var  logic scl,
	output var  logic oe
);
	initial begin
		scl = 1'b1;
		oe = 1'b0;
	end
	task automatic hp();
		repeat (2) @(negedge clock);
	endtask
	// Data moves only mid-low so no false start or stop
	task automatic bit_io(input logic b, output logic r);
		hp();
		oe = !b;
		hp();
		scl = 1'b1;
		hp();
		hp();
		r = sda;
		scl = 1'b0;
	endtask
	task automatic start();
		hp();
		oe = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		oe = 1'b1;
		hp();
		scl = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] r,
		output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(ab, a);
	endtask
	task automatic stop();
		hp();
		oe = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		oe = 1'b0;
		hp();
	endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam [39:0] TCYC = 40'd100;
	logic clock = 0, rst = 1, bpn = 1, en = 1, byp_n = 1, adp = 0, pre = 0, vr = 0;
	logic eocr = 0, rech = 0, ret = 1, a;
	logic [7:0] q_setup = 8'h00, q_stat = 8'h01, r, rv;
	wire sda_oe, sda_out, scl, m_oe, frm, con, cc, cvo, vh, red, grn;
	wire [9:0] ima;
	wire [1:0] eoc;
	// Pulled-up open-drain line
	wire sda = !(sda_oe | m_oe);
	integer err_total = 0, n_checks = 0, cyc = 0;
	always #12.5 clock = !clock;
	cmt_charger_ctrl #(.TIMER_CYCLES(TCYC)) dut (
		.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .battery_present_n(bpn), .charger_enable(en),
		.timer_bypass_n(byp_n), .adapter_ok(adp), .precharge_done(pre),
		.voltage_reached(vr), .eoc_current_reached(eocr), .recharge_needed(rech),
		.battery_above_retention(ret), .fixed_regulator_mode(frm), .charger_on(con),
		.cc_phase(cc), .cv_only(cvo), .charge_current_ma(ima), .vreg_high(vh),
		.eoc_select(eoc), .red_led_n_oe(red), .green_led_n_oe(grn));
	cmt_i2c_master m (.clock(clock), .sda(sda), .scl(scl), .oe(m_oe));
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop();
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		m.start();
		m.byte_io(8'h8A, 1'b1, r, a);
		chk("ack", 10'h0, {9'h0, a});
		m.byte_io(ad, 1'b1, r, a);
		m.byte_io(d, 1'b1, r, a);
		m.stop();
		if (ad == 8'h00)
			q_setup = d & 8'h3F;
		if (ad == 8'h01)
			q_stat = d & 8'h03;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		m.start();
		m.byte_io(8'h8A, 1'b1, r, a);
		m.byte_io(ad, 1'b1, r, a);
		m.start();
		m.byte_io(8'h8B, 1'b1, r, a);
		m.byte_io(8'hFF, 1'b1, r, a);
		m.stop();
		chk("rd", {2'h0, e}, {2'h0, r});
	endtask
	task automatic leds(input logic [1:0] e);
		chk("leds", {8'h0, e}, {8'h0, red, grn});
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc > 40000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(39998));
		repeat (12) @(posedge clock);
		@(negedge clock) rst = 0;
		tick(4);
		chk("mode", 10'h1, {9'h0, frm});
		chk("ima", 10'd500, ima);
		chk("sda_out", 10'h0, {9'h0, sda_out});
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h01);
		for (int i = 0; i < 16; i++) begin
			rv = $urandom;
			wr(8'h00, {rv[7:4], i[3:0]});
			wr(8'h01, rv);
			rd(8'h00, q_setup);
			rd(8'h01, q_stat);
			chk("ima", 10'(500 + 50 * (i > 9 ? 9 : i)), ima);
			chk("vsel", {9'h0, q_setup[4]}, {9'h0, vh});
			chk("eocsel", {8'h0, q_stat[1:0]}, {8'h0, eoc});
		end
		m.start();
		m.byte_io(8'h8C, 1'b1, r, a);
		m.stop();
		chk("nack", 10'h1, {9'h0, a});
		wr(8'h07, 8'hFF);
		rd(8'h00, q_setup);
		ret = 0;
		tick(4);
		ret = 1;
		q_setup = 8'h00;
		q_stat = 8'h01;
		rd(8'h00, q_setup);
		rd(8'h01, q_stat);
		wr(8'h00, 8'h05);
		bpn = 0;
		adp = 1;
		pre = 1;
		tick(8);
		chk("mode", 10'h0, {9'h0, frm});
		chk("cc", 10'h1, {9'h0, cc});
		leds(2'h2);
		vr = 1;
		tick(6);
		chk("cc", 10'h0, {9'h0, cc});
		eocr = 1;
		tick(6);
		leds(2'h1);
		wr(8'h01, 8'h0E);
		rd(8'h01, {4'h0, 2'b10, q_stat[1:0]});
		rech = 1;
		vr = 0;
		eocr = 0;
		tick(6);
		leds(2'h1);
		en = 0;
		tick(6);
		chk("on", 10'h0, {9'h0, con});
		leds(2'h1);
		rech = 0;
		en = 1;
		tick(110);
		chk("on", 10'h0, {9'h0, con});
		leds(2'h3);
		en = 0;
		tick(4);
		byp_n = 0;
		en = 1;
		tick(112);
		chk("cc", 10'h0, {9'h0, cc});
		leds(2'h1);
		wr(8'h00, 8'h25);
		tick(120);
		chk("cvo", 10'h1, {9'h0, cvo});
		chk("on", 10'h1, {9'h0, con});
		chk("ima", 10'd750, ima);
		leds(2'h2);
		rd(8'h01, {4'h0, 2'b01, q_stat[1:0]});
		bpn = 1;
		tick(6);
		chk("mode", 10'h1, {9'h0, frm});
		leds(2'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
